/* core/sep_eeprom.sv */
// two-wire client: ack polling and current, random, sequential reads
`timescale 1ns/100ps
`default_nettype none
// How it works
// - no acknowledge of any byte while programming runs.
// - stop after a written data byte starts programming; polling may follow.
// - busy gives no acknowledge, finished gives acknowledge.
// - direction bit one selects read; three read forms supported.
// - pointer holds last accessed location plus one.
// - read control byte acknowledged, then pointer byte shifted out.
// - host no-acknowledge then stop ends read; data line released.
// - repeated start after address aborts write, pointer kept.
// - read control after repeated start sends byte at loaded address.
// - host acknowledge brings the next sequential byte.
// - pointer advances by one after each byte.
// - bus lines filtered of short spikes before decoding.
// - only four type bits matched; three bits ignored; last bit direction.
// - only seven low address bits loaded.
// - host no-acknowledge releases data line high.
module sep_eeprom (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output var  logic sda_out_r,
    output var  logic sda_oe_n_r,
    output var  logic busy_r
);
    import sep_pkg::*;

    // ********************************
    // input conditioning
    // ********************************
    sep_bus_t line;
    sep_evt_t evt;
    sep_bus_t pin;

    // raw pins only; the filter stage owns both synchroniser flops
    assign pin = '{scl: scl_in, sda: sda_in};

    sep_filter u_filter (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .pin_in   (pin),
        .line_r   (line),
        .evt_r    (evt)
    );

    // ********************************
    // state
    // ********************************
    logic [7:0]        mem [DEPTH];
    sep_state_t        st_r, st_nxt;
    logic [3:0]        bit_r, bit_nxt;
    logic [7:0]        sh_r, sh_nxt;
    logic [ADDR_W-1:0] ptr_r, ptr_nxt;
    logic              drv_r, drv_nxt;
    logic              hack_r, hack_nxt;
    logic              wr_r, wr_nxt;
    logic [19:0]       prog_r, prog_nxt;
    logic              mwe;

    function automatic logic [ADDR_W-1:0] inc(input logic [ADDR_W-1:0] a);
        inc = ADDR_W'(a + 1'b1);
    endfunction : inc

    // states in which the host is sending and every clock rise is a bit
    function automatic logic is_rx(input sep_state_t s);
        is_rx = (s == SEP_CTRL) || (s == SEP_ADDR) || (s == SEP_WDAT);
    endfunction : is_rx

    // drive flag for the leading bit, then the rest of the byte to shift
    function automatic logic [8:0] load_byte(input logic [7:0] b);
        load_byte = {~b[7], b[6:0], 1'b0};
    endfunction : load_byte

    // ********************************
    // bit level decode
    // ********************************
    always_comb begin
        st_nxt   = st_r;
        bit_nxt  = bit_r;
        sh_nxt   = sh_r;
        ptr_nxt  = ptr_r;
        drv_nxt  = drv_r;
        hack_nxt = hack_r;
        wr_nxt   = wr_r;
        // counts down; the array is free again the cycle it hits zero
        prog_nxt = (prog_r != 20'h0) ? prog_r - 20'h1 : prog_r;
        mwe      = 1'b0;
        // a start always wins: the host may abort any transfer
        if (evt.start) begin
            // repeated start skips programming; bytes already stored stay, pointer stays
            st_nxt  = SEP_CTRL;
            bit_nxt = 4'h0;
            drv_nxt = 1'b0;
            wr_nxt  = 1'b0;
        end else if (evt.stop) begin
            // stop after a written byte starts programming
            if (wr_r) prog_nxt = PROG_CNT;
            wr_nxt  = 1'b0;
            st_nxt  = SEP_IDLE;
            drv_nxt = 1'b0;
        end else if (evt.scl_rise) begin
            if (is_rx(st_r)) begin
                sh_nxt  = {sh_r[6:0], line.sda};
                bit_nxt = bit_r + 4'h1;
            end
            if (st_r == SEP_RACK) hack_nxt = ~line.sda;
        end else if (evt.scl_fall) begin
            case (st_r)
                SEP_CTRL: if (bit_r == BIT_FULL) begin
                    // type bits only; busy means silence
                    if (sh_r[7:4] == DEV_TYPE && prog_r == 20'h0) begin
                        st_nxt  = SEP_CACK;
                        drv_nxt = 1'b1;
                    end else begin
                        st_nxt = SEP_IDLE;
                    end
                end
                SEP_CACK: begin
                    bit_nxt = 4'h0;
                    if (sh_r[0]) begin
                        st_nxt  = SEP_RDAT;
                        {drv_nxt, sh_nxt} = load_byte(mem[ptr_r]);
                        ptr_nxt = inc(ptr_r);
                    end else begin
                        st_nxt  = SEP_ADDR;
                        drv_nxt = 1'b0;
                    end
                end
                SEP_ADDR: if (bit_r == BIT_FULL) begin
                    ptr_nxt = sh_r[ADDR_W-1:0];
                    st_nxt  = SEP_WACK;
                    drv_nxt = 1'b1;
                end
                SEP_WDAT: if (bit_r == BIT_FULL) begin
                    mwe     = 1'b1;
                    wr_nxt  = 1'b1;
                    ptr_nxt = inc(ptr_r);
                    st_nxt  = SEP_WACK;
                    drv_nxt = 1'b1;
                end
                SEP_WACK: begin
                    // host resumes driving; let go before its next bit
                    st_nxt  = SEP_WDAT;
                    bit_nxt = 4'h0;
                    drv_nxt = 1'b0;
                end
                SEP_RDAT: begin
                    // release after the last bit: the host owns the ack slot
                    if (bit_r == BIT_LAST) begin
                        st_nxt  = SEP_RACK;
                        drv_nxt = 1'b0;
                    end else begin
                        drv_nxt = ~sh_r[7];
                        sh_nxt  = {sh_r[6:0], 1'b0};
                        bit_nxt = bit_r + 4'h1;
                    end
                end
                SEP_RACK: begin
                    bit_nxt = 4'h0;
                    if (hack_r) begin
                        st_nxt  = SEP_RDAT;
                        {drv_nxt, sh_nxt} = load_byte(mem[ptr_r]);
                        ptr_nxt = inc(ptr_r);
                    end else begin
                        st_nxt  = SEP_IDLE;
                        drv_nxt = 1'b0;
                    end
                end
                default: st_nxt = st_r;
            endcase
        end
    end

    // ********************************
    // byte store
    // ********************************
    // minimal byte store so pointer writes and reads have data behind them
    always_ff @(posedge core_clk) begin
        if (mwe) mem[ptr_r] <= sh_r;
    end

    // ********************************
    // registers
    // ********************************
    // outputs come straight from flops; no logic after them
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r       <= SEP_IDLE;
            bit_r      <= 4'h0;
            sh_r       <= 8'h00;
            ptr_r      <= PTR_RST;
            drv_r      <= 1'b0;
            hack_r     <= 1'b0;
            wr_r       <= 1'b0;
            prog_r     <= 20'h0;
            sda_out_r  <= 1'b0;
            sda_oe_n_r <= 1'b1;
            busy_r     <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            bit_r      <= bit_nxt;
            sh_r       <= sh_nxt;
            ptr_r      <= ptr_nxt;
            drv_r      <= drv_nxt;
            hack_r     <= hack_nxt;
            wr_r       <= wr_nxt;
            prog_r     <= prog_nxt;
            sda_out_r  <= 1'b0;
            // open drain: pull low only, released otherwise
            sda_oe_n_r <= ~drv_nxt;
            busy_r     <= (prog_nxt != 20'h0);
        end
    end
endmodule : sep_eeprom
`default_nettype wire

/* core/sep_filter.sv */
// glitch filter and edge finder for the two bus lines
`timescale 1ns/100ps
`default_nettype none
module sep_filter (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire sep_pkg::sep_bus_t pin_in,
    output var  sep_pkg::sep_bus_t line_r,
    output var  sep_pkg::sep_evt_t evt_r
);
    import sep_pkg::*;

    sep_bus_t s1_r, s2_r, lnxt;
    sep_evt_t enxt;
    logic [FILT_LEN-1:0] hs_r, hd_r, hs_nxt, hd_nxt;

    always_comb begin
        hs_nxt = {hs_r[FILT_LEN-2:0], s2_r.scl};
        hd_nxt = {hd_r[FILT_LEN-2:0], s2_r.sda};
        lnxt   = line_r;
        // spikes shorter than the window never reach the line state
        if (&hs_nxt) lnxt.scl = 1'b1;
        if (~|hs_nxt) lnxt.scl = 1'b0;
        if (&hd_nxt) lnxt.sda = 1'b1;
        if (~|hd_nxt) lnxt.sda = 1'b0;
        enxt.scl_rise = lnxt.scl & ~line_r.scl;
        enxt.scl_fall = ~lnxt.scl & line_r.scl;
        enxt.start = line_r.scl & lnxt.scl & line_r.sda & ~lnxt.sda;
        enxt.stop  = line_r.scl & lnxt.scl & ~line_r.sda & lnxt.sda;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r   <= '1;
            s2_r   <= '1;
            hs_r   <= '1;
            hd_r   <= '1;
            line_r <= '1;
            evt_r  <= '0;
        end else begin
            s1_r   <= pin_in;
            s2_r   <= s1_r;
            hs_r   <= hs_nxt;
            hd_r   <= hd_nxt;
            line_r <= lnxt;
            evt_r  <= enxt;
        end
    end
endmodule : sep_filter
`default_nettype wire

/* core/sep_pkg.sv */
// shared constants and types of the serial eeprom read and poll logic
package sep_pkg;

    localparam int unsigned ADDR_W      = 7;
    localparam int unsigned DEPTH       = 128;
    // device type code, value arbitrary
    localparam logic [3:0]  DEV_TYPE    = 4'h6;
    localparam logic [6:0]  PTR_RST     = 7'h00;
    localparam logic [7:0]  MEM_RST     = 8'hff;
    localparam int unsigned FILT_LEN    = 3;
    localparam logic [3:0]  BIT_LAST    = 4'h7;
    localparam logic [3:0]  BIT_FULL    = 4'h8;
    // self-timed programming time, default kept small for simulation
    localparam int unsigned PROG_CYC    = 1000;
    localparam logic [19:0] PROG_CNT    = 20'(PROG_CYC);

    typedef enum logic [2:0] {
        SEP_IDLE  = 3'b000,
        SEP_CTRL  = 3'b001,
        SEP_CACK  = 3'b011,
        SEP_ADDR  = 3'b010,
        SEP_WDAT  = 3'b110,
        SEP_RDAT  = 3'b111,
        SEP_RACK  = 3'b101,
        SEP_WACK  = 3'b100
    } sep_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } sep_bus_t;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } sep_evt_t;

endpackage : sep_pkg

/* test/sep_eeprom_tb_top.sv */
// testbench top: acknowledge polling and the three read forms
`timescale 1ns/100ps
`default_nettype none
module sep_eeprom_tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sda_oe_n_r, sda_out_r, busy_r, scl, sda_host;
    wire  sda_line;
    int   err_total = 0;
    int   total_checks = 0;
    // control bytes built from the type code; block bits vary on purpose
    localparam logic [7:0] CTL_WR  = {sep_pkg::DEV_TYPE, 4'he};
    localparam logic [7:0] CTL_RD  = {sep_pkg::DEV_TYPE, 4'h1};
    localparam logic [7:0] CTL_RD3 = {sep_pkg::DEV_TYPE, 4'h3};
    // open drain with pull-up
    assign sda_line = sda_host & (sda_oe_n_r | sda_out_r);
    always #5 core_clk = ~core_clk;
    sep_host i_host (.core_clk(core_clk), .sda_in(sda_line), .scl(scl),
        .sda(sda_host));
    sep_eeprom i_dut (.core_clk(core_clk), .reset_n(reset_n), .scl_in(scl),
        .sda_in(sda_line), .sda_out_r(sda_out_r), .sda_oe_n_r(sda_oe_n_r),
        .busy_r(busy_r));
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [8:0] seen,
                       input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // write control with don't-care block bits set; bounded retries
    task automatic poll(output int n);
        logic [8:0] r;
        n = 0;
        r = 9'h1ff;
        while (r[0] && n < 40) begin
            i_host.start_c();
            i_host.xfer({CTL_WR, 1'b1}, r);
            n++;
            if (r[0]) i_host.stop_c();
        end
        if (r[0]) begin
            chk("poll bound", r, {CTL_WR, 1'b0});
            wrap_up();
        end
    endtask : poll
    task automatic write_b(input logic [7:0] a, input logic [7:0] d,
                           input bit wt);
        logic [8:0] r;
        int n;
        poll(n);
        i_host.xfer({a, 1'b1}, r);
        chk("addr ack", 9'(r[0]), 9'h0);
        i_host.xfer({d, 1'b1}, r);
        chk("data ack", 9'(r[0]), 9'h0);
        i_host.stop_c();
        chk("busy", 9'(busy_r), 9'h1);
        if (wt) begin
            poll(n);
            chk("busy polls", 9'(n > 1), 9'h1);
            chk("done", 9'(busy_r), 9'h0);
            i_host.stop_c();
        end
    endtask : write_b
    task automatic sc_reads();
        logic [8:0] r;
        int n;
        write_b(8'h00, 8'ha5, 1'b1);
        write_b(8'hff, 8'h5a, 1'b1);
        i_host.start_c();
        i_host.xfer({CTL_RD, 1'b1}, r);
        chk("read ctrl ack", r, {CTL_RD, 1'b0});
        i_host.xfer({8'hff, 1'b1}, r);
        chk("current byte", r, {8'ha5, 1'b1});
        i_host.stop_c();
        chk("released", 9'(sda_oe_n_r), 9'h1);
        poll(n);
        i_host.xfer({8'hff, 1'b1}, r);
        i_host.start_c();
        i_host.xfer({CTL_RD3, 1'b1}, r);
        chk("random ctrl ack", r, {CTL_RD3, 1'b0});
        i_host.xfer({8'hff, 1'b0}, r);
        chk("random byte", r, {8'h5a, 1'b0});
        i_host.xfer({8'hff, 1'b1}, r);
        chk("next byte", r, {8'ha5, 1'b1});
        i_host.stop_c();
        chk("released", 9'(sda_oe_n_r), 9'h1);
        chk("drive level", 9'(sda_out_r), 9'h0);
    endtask : sc_reads
    task automatic sc_refuse();
        logic [8:0] r;
        int n;
        i_host.start_c();
        i_host.xfer({8'h91, 1'b1}, r);
        chk("foreign type", r, {8'h91, 1'b1});
        i_host.xfer({CTL_RD, 1'b1}, r);
        chk("no start", r, {CTL_RD, 1'b1});
        i_host.stop_c();
        write_b(8'hff, 8'h11, 1'b0);
        i_host.start_c();
        i_host.xfer({CTL_RD, 1'b1}, r);
        chk("read while busy", r, {CTL_RD, 1'b1});
        i_host.stop_c();
        poll(n);
        i_host.stop_c();
        i_host.start_c();
        i_host.xfer({CTL_RD, 1'b1}, r);
        chk("ready ctrl ack", r, {CTL_RD, 1'b0});
        i_host.xfer({8'hff, 1'b1}, r);
        chk("after write", r, {8'ha5, 1'b1});
        i_host.stop_c();
    endtask : sc_refuse
    initial begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        sc_reads();
        sc_refuse();
        wrap_up();
    end
endmodule : sep_eeprom_tb_top
bind sep_eeprom sep_props i_props (.core_clk(core_clk), .reset_n(reset_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out_r(sda_out_r),
    .sda_oe_n_r(sda_oe_n_r), .busy_r(busy_r));
`default_nettype wire

/* test/sep_host.sv */
// host partner model: bus clock, start, stop and bit transfers
`timescale 1ns/100ps
`default_nettype none
module sep_host (
    input  wire logic core_clk,
    input  wire logic sda_in,
    output var  logic scl,
    output var  logic sda
);
    // long halves so answers land well inside the clock low phase
    localparam int HALF = 20;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // data moves first, clock two cycles later, never together
    task automatic lv(input logic d, input logic c);
        sda <= d;
        repeat (2) @(posedge core_clk);
        scl <= c;
        repeat (HALF) @(posedge core_clk);
    endtask : lv
    task automatic start_c();
        lv(1'b1, scl);
        lv(1'b1, 1'b1);
        lv(1'b0, 1'b1);
        lv(1'b0, 1'b0);
    endtask : start_c
    task automatic stop_c();
        lv(1'b0, 1'b0);
        lv(1'b0, 1'b1);
        lv(1'b1, 1'b1);
    endtask : stop_c
    // msb first, ninth bit is the acknowledge slot
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            lv(tx[i], 1'b1);
            rx[i] = sda_in;
            lv(tx[i], 1'b0);
        end
    endtask : xfer
endmodule : sep_host
`default_nettype wire

/* test/sep_props.sv */
// checker of the serial eeprom client pins
`timescale 1ns/100ps
`default_nettype none
module sep_props (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out_r,
    input wire logic sda_oe_n_r,
    input wire logic busy_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // programming length is counted; too long for a delay range
    logic [10:0] busy_cnt;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt <= 11'h000;
        end else if (!busy_r) begin
            busy_cnt <= 11'h000;
        end else if (busy_cnt != 11'h7ff) begin
            busy_cnt <= busy_cnt + 11'h001;
        end
    end
    // ***********************
    // bus events
    // ***********************
    sequence stop_seen;
        scl_in && $rose(sda_in);
    endsequence
    sequence prog_run;
        $rose(busy_r) ##1 busy_r[*7];
    endsequence
    out_zero_a: assert property (sda_out_r == 1'b0)
        else $error("data output level not zero");
    busy_quiet_a: assert property (busy_r |-> sda_oe_n_r)
        else $error("line driven while programming");
    busy_min_a: assert property ($rose(busy_r) |-> prog_run)
        else $error("programming ended too soon");
    prog_len_a: assert property (
        $fell(busy_r) |-> busy_cnt == 11'(sep_pkg::PROG_CYC))
        else $error("programming time wrong");
    busy_idle_a: assert property ($rose(busy_r) |-> scl_in && sda_in)
        else $error("programming began with bus not idle");
    edge_low_a: assert property ($changed(sda_oe_n_r) |-> !scl_in)
        else $error("data line changed while clock high");
    // changes only after the clock fall has passed the filter
    filt_lag_a: assert property (
        $changed(sda_oe_n_r) |-> !$past(scl_in, 3))
        else $error("data line changed too soon after clock fall");
    ack_hold_a: assert property (
        $rose(scl_in) && !sda_oe_n_r |-> !sda_oe_n_r[*8])
        else $error("driven bit not held through clock high");
    stop_free_a: assert property (stop_seen |-> sda_oe_n_r[*8])
        else $error("line driven after stop");
endmodule : sep_props
`default_nettype wire
